// ---- verilog/crs_regset.sv ----
// The implementer's own choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ns
// CPU register set with two banks and Wishbone access, plus address decode
// Summary of operation
// - Decode full 20-bit one-megabyte space, narrow regions ahead of the wide ROM span.
// - Internal RAM answers at 00400h through 017FFh.
// - Peripheral register area covers 00000h through 003FFh.
// - Fixed interrupt vectors decode at FFFDCh through FFFFFh.
// - Special-page vector table decodes at FFE00h through FFFDBh.
// - Expansion mode marks 01800h-03FFFh and D0000h-DFFFFh reserved, not external.
// - Top 128 kilobytes decode as internal ROM.
// - Thirteen registers; data, address and frame base exist in two banks.
// - Four 16-bit data registers.
// - Data registers zero and one accessible as separate high and low bytes.
// - Data two with zero, and three with one, pair into 32-bit registers.
// - Two 16-bit address registers, also pairable into one 32-bit register.
// - A 16-bit frame base register.
// - A 20-bit program counter.
// - A 20-bit vector table base register.
// - User and interrupt 16-bit stack pointers, chosen by flag bit 7.
// - A 16-bit static base register.
// - Flag word implements eleven defined bits.
// - Stack flag 0 picks interrupt pointer, 1 user; interrupt acknowledge clears it.
// - Flag bit 4 selects bank zero or bank one.
module crs_regset (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [7:2] WB_ADR_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic HW_INT_ACK,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    output logic WB_ERR_O,
    output logic [15:0] ACTIVE_SP,
    output logic BANK_SEL,
    output crs_pkg::crs_decode_t DEC_OUT
);
    import crs_pkg::*;

    // Banked storage, index [bank][reg]: 0..3 data, 4..5 address, 6 frame
    logic [15:0] bank_ff [2][7];
    logic [19:0] pc_ff;
    logic [19:0] vtb_ff;
    logic [15:0] usp_ff;
    logic [15:0] isp_ff;
    logic [15:0] sb_ff;
    logic [15:0] flags_ff;
    logic mode_ff;
    logic [19:0] dec_addr_ff;
    logic ack_ff;
    logic err_ff;
    logic [31:0] rdat_ff;
    logic [15:0] act_sp_ff;
    logic bank_out_ff;
    crs_wb_req_t req;
    logic req_new;
    logic wr_en;
    logic map_hit;
    logic bsel;
    logic [31:0] nxt_rdat;
    logic [15:0] byte_wmask;
    crs_decode_t dec_w;
    logic wr_pc;
    logic wr_vtb;
    logic wr_usp;
    logic wr_isp;
    logic wr_sb;
    logic wr_flags;
    logic wr_mode;
    logic wr_probe;

    // Word index map on the bus (byte address is index times four):
    //   00-03  data registers zero to three, selected bank
    //   04-05  address registers zero and one, selected bank
    //   06     frame base, selected bank
    //   07     program counter, 20 bits
    //   08     vector table base, 20 bits
    //   09     user stack pointer
    //   0a     interrupt stack pointer
    //   0b     static base
    //   0c     flag word, only implemented bits stick
    //   0d     active stack pointer, steered by the stack flag
    //   0e     processor mode, bit 0 set for memory expansion
    //   0f     decoder probe address
    //   10     decoder result, read only; writes are acked and dropped
    //   11     data zero and two as one 32-bit word
    //   12     data one and three as one 32-bit word
    //   13     address zero and one as one 32-bit word
    //   14     low bytes of data zero (lane 0) and data one (lane 1)
    //   15     high bytes of data zero (lane 0) and data one (lane 1)
    //   16-3f  unmapped, answered with err and never written
    // Wide and 20-bit entries take the whole word whatever the lane selects;
    // banked sixteen-bit entries honour lanes 0 and 1, the other sixteen-bit ones take both bytes; byte entries one lane each.

    assign req = '{cyc: WB_CYC_I, stb: WB_STB_I, we: WB_WE_I, sel: WB_SEL_I,
                   idx: WB_ADR_I, dat: WB_DAT_I};
    // One answer per request: ack drops the cycle after it is given
    assign req_new = req.cyc && req.stb && !ack_ff && !err_ff;
    assign wr_en = req_new && req.we && map_hit;
    assign bsel = flags_ff[FLG_BANK_BIT];
    assign byte_wmask = {{8{req.sel[1]}}, {8{req.sel[0]}}};

    // Known register indices
    always_comb begin
        map_hit = (req.idx <= REG_BYTE_HI);
    end

    // Bus answer: ack for mapped indices, one cycle each
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= req_new && map_hit;
        end
    end

    // Refusal kept apart so a bad index never looks like a completed access
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            err_ff <= 1'b0;
        end else begin
            err_ff <= req_new && !map_hit;
        end
    end

    // Write strobes for the unbanked set; the alias follows the stack flag of this cycle,
    // so an acknowledge in the same cycle does not redirect a write already under way
    always_comb begin
        wr_pc = wr_en && (req.idx == REG_PC);
        wr_vtb = wr_en && (req.idx == REG_VTB);
        wr_usp = wr_en && (req.idx == REG_USP
            || (req.idx == REG_ACT_SP && flags_ff[FLG_STACK_BIT]));
        wr_isp = wr_en && (req.idx == REG_ISP
            || (req.idx == REG_ACT_SP && !flags_ff[FLG_STACK_BIT]));
        wr_sb = wr_en && (req.idx == REG_SB);
        wr_flags = wr_en && (req.idx == REG_FLAGS);
        wr_mode = wr_en && (req.idx == REG_MODE);
        wr_probe = wr_en && (req.idx == REG_DEC_ADDR);
    end

    // Banked words, one flop per bank and entry; only the selected bank is touched,
    // so flipping the bank flag never disturbs the hidden copy
    for (genvar b = 0; b < 2; b++) begin : g_bank
        for (genvar r = 0; r < 7; r++) begin : g_word
            logic hit;
            logic [15:0] nxt_word;

            // Which bus index reaches this word, and with what value
            always_comb begin
                hit = 1'b0;
                nxt_word = bank_ff[b][r];
                if (req.idx == 6'(r)) begin
                    hit = 1'b1;
                    nxt_word = (bank_ff[b][r] & ~byte_wmask) | (req.dat[15:0] & byte_wmask);
                end else if (req.idx == REG_WIDE_DATA_LO && (r == 0 || r == 2)) begin
                    hit = 1'b1;
                    nxt_word = (r == 0) ? req.dat[15:0] : req.dat[31:16];
                end else if (req.idx == REG_WIDE_DATA_HI && (r == 1 || r == 3)) begin
                    hit = 1'b1;
                    nxt_word = (r == 1) ? req.dat[15:0] : req.dat[31:16];
                end else if (req.idx == REG_WIDE_ADDR && (r == 4 || r == 5)) begin
                    hit = 1'b1;
                    nxt_word = (r == 4) ? req.dat[15:0] : req.dat[31:16];
                end else if (req.idx == REG_BYTE_LO && r < 2) begin
                    // Lane 0 carries data zero, lane 1 data one
                    hit = req.sel[r % 2];
                    nxt_word[7:0] = req.dat[8 * (r % 2) +: 8];
                end else if (req.idx == REG_BYTE_HI && r < 2) begin
                    hit = req.sel[r % 2];
                    nxt_word[15:8] = req.dat[8 * (r % 2) +: 8];
                end
            end

            // Storage for this word
            always_ff @(posedge CLK or negedge ARST_N) begin
                if (!ARST_N) begin
                    bank_ff[b][r] <= REG16_RESET;
                end else if (wr_en && hit && (bsel == 1'(b))) begin
                    bank_ff[b][r] <= nxt_word;
                end
            end
        end
    end

    // Program counter, 20 bits, whole word whatever the lanes
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pc_ff <= REG20_RESET;
        end else if (wr_pc) begin
            pc_ff <= req.dat[19:0];
        end
    end

    // Vector table base, 20 bits, whole word
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            vtb_ff <= REG20_RESET;
        end else if (wr_vtb) begin
            vtb_ff <= req.dat[19:0];
        end
    end

    // User stack pointer, reached directly or through the alias
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            usp_ff <= REG16_RESET;
        end else if (wr_usp) begin
            usp_ff <= req.dat[15:0];
        end
    end

    // Interrupt stack pointer, reached directly or through the alias
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            isp_ff <= REG16_RESET;
        end else if (wr_isp) begin
            isp_ff <= req.dat[15:0];
        end
    end

    // Static base
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sb_ff <= REG16_RESET;
        end else if (wr_sb) begin
            sb_ff <= req.dat[15:0];
        end
    end

    // Flag word; acknowledge wins over a same-cycle software write of the stack bit.
    // Bits outside the implemented mask always read back as zero.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            flags_ff <= FLG_RESET;
        end else begin
            if (wr_flags) begin
                flags_ff <= req.dat[15:0] & FLG_IMPL_MASK;
            end
            if (HW_INT_ACK) begin
                flags_ff[FLG_STACK_BIT] <= 1'b0;
            end
        end
    end

    // Expansion mode bit
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            mode_ff <= 1'b0;
        end else if (wr_mode) begin
            mode_ff <= req.dat[0];
        end
    end

    // Decoder probe address; the result shows one cycle after this register moves
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            dec_addr_ff <= REG20_RESET;
        end else if (wr_probe) begin
            dec_addr_ff <= req.dat[19:0];
        end
    end

    crs_addr_decode u_dec (
        .clk(CLK),
        .arst_n(ARST_N),
        .addr(dec_addr_ff),
        .expand_mode(mode_ff),
        .dec_ff(dec_w)
    );

    // Read mux, banked entries from the currently selected bank
    always_comb begin
        nxt_rdat = 32'h0000_0000;
        case (req.idx)
            REG_DATA0, REG_DATA1, REG_DATA2, REG_DATA3,
            REG_ADDR0, REG_ADDR1, REG_FRAME: nxt_rdat = {16'h0000, bank_ff[bsel][req.idx[2:0]]};
            REG_PC: nxt_rdat = {12'h000, pc_ff};
            REG_VTB: nxt_rdat = {12'h000, vtb_ff};
            REG_USP: nxt_rdat = {16'h0000, usp_ff};
            REG_ISP: nxt_rdat = {16'h0000, isp_ff};
            REG_SB: nxt_rdat = {16'h0000, sb_ff};
            REG_FLAGS: nxt_rdat = {16'h0000, flags_ff};
            REG_ACT_SP: nxt_rdat = {16'h0000, flags_ff[FLG_STACK_BIT] ? usp_ff : isp_ff};
            REG_MODE: nxt_rdat = {31'h0000_0000, mode_ff};
            REG_DEC_ADDR: nxt_rdat = {12'h000, dec_addr_ff};
            REG_DEC_RES: nxt_rdat = {27'h000_0000, dec_w};
            REG_WIDE_DATA_LO: nxt_rdat = {bank_ff[bsel][2], bank_ff[bsel][0]};
            REG_WIDE_DATA_HI: nxt_rdat = {bank_ff[bsel][3], bank_ff[bsel][1]};
            REG_WIDE_ADDR: nxt_rdat = {bank_ff[bsel][5], bank_ff[bsel][4]};
            REG_BYTE_LO: nxt_rdat = {16'h0000, bank_ff[bsel][1][7:0], bank_ff[bsel][0][7:0]};
            REG_BYTE_HI: nxt_rdat = {16'h0000, bank_ff[bsel][1][15:8], bank_ff[bsel][0][15:8]};
            default: nxt_rdat = 32'h0000_0000;
        endcase
    end

    // Read data only while answering, zero otherwise, so a stale word never lingers.
    // A write answers with the old contents of the register it hits.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rdat_ff <= 32'h0000_0000;
        end else begin
            rdat_ff <= req_new ? nxt_rdat : 32'h0000_0000;
        end
    end

    // Active stack pointer copy, one cycle behind the flag
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            act_sp_ff <= REG16_RESET;
        end else begin
            act_sp_ff <= flags_ff[FLG_STACK_BIT] ? usp_ff : isp_ff;
        end
    end

    // Bank flag copy for the execution side, one cycle behind the flag
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            bank_out_ff <= 1'b0;
        end else begin
            bank_out_ff <= bsel;
        end
    end

    assign WB_DAT_O = rdat_ff;
    assign WB_ACK_O = ack_ff;
    assign WB_ERR_O = err_ff;
    assign ACTIVE_SP = act_sp_ff;
    assign BANK_SEL = bank_out_ff;
    assign DEC_OUT = dec_w;
endmodule : crs_regset

// ---- inc/crs_pkg.sv ----
// Package for the CPU register set and address map block
package crs_pkg;
    // Register indices on the Wishbone bus (byte address = index * 4)
    localparam logic [5:0] REG_DATA0 = 6'h00;
    localparam logic [5:0] REG_DATA1 = 6'h01;
    localparam logic [5:0] REG_DATA2 = 6'h02;
    localparam logic [5:0] REG_DATA3 = 6'h03;
    localparam logic [5:0] REG_ADDR0 = 6'h04;
    localparam logic [5:0] REG_ADDR1 = 6'h05;
    localparam logic [5:0] REG_FRAME = 6'h06;
    localparam logic [5:0] REG_PC = 6'h07;
    localparam logic [5:0] REG_VTB = 6'h08;
    localparam logic [5:0] REG_USP = 6'h09;
    localparam logic [5:0] REG_ISP = 6'h0a;
    localparam logic [5:0] REG_SB = 6'h0b;
    localparam logic [5:0] REG_FLAGS = 6'h0c;
    localparam logic [5:0] REG_ACT_SP = 6'h0d;
    localparam logic [5:0] REG_MODE = 6'h0e;
    localparam logic [5:0] REG_DEC_ADDR = 6'h0f;
    localparam logic [5:0] REG_DEC_RES = 6'h10;
    localparam logic [5:0] REG_WIDE_DATA_LO = 6'h11;
    localparam logic [5:0] REG_WIDE_DATA_HI = 6'h12;
    localparam logic [5:0] REG_WIDE_ADDR = 6'h13;
    localparam logic [5:0] REG_BYTE_LO = 6'h14;
    localparam logic [5:0] REG_BYTE_HI = 6'h15;

    // Flag word bit positions
    localparam int FLG_BANK_BIT = 4;
    localparam int FLG_STACK_BIT = 7;
    localparam logic [15:0] FLG_IMPL_MASK = 16'h70ff;
    localparam logic [15:0] FLG_RESET = 16'h0000;
    localparam logic [15:0] REG16_RESET = 16'h0000;
    localparam logic [19:0] REG20_RESET = 20'h00000;

    // Address map boundaries
    localparam logic [19:0] ADDR_SFR_LAST = 20'h003ff;
    localparam logic [19:0] ADDR_RAM_FIRST = 20'h00400;
    localparam logic [19:0] ADDR_RAM_LAST = 20'h017ff;
    localparam logic [19:0] ADDR_RES0_FIRST = 20'h01800;
    localparam logic [19:0] ADDR_RES0_LAST = 20'h03fff;
    localparam logic [19:0] ADDR_RES1_FIRST = 20'hd0000;
    localparam logic [19:0] ADDR_RES1_LAST = 20'hdffff;
    localparam logic [19:0] ADDR_ROM_FIRST = 20'he0000;
    localparam logic [19:0] ADDR_SPV_FIRST = 20'hffe00;
    localparam logic [19:0] ADDR_SPV_LAST = 20'hffdb + 20'hf0000;
    localparam logic [19:0] ADDR_FIXV_FIRST = 20'hffdc + 20'hf0000;

    // Region codes
    typedef enum logic [2:0] {
        RGN_SFR, RGN_RAM, RGN_ROM, RGN_SPECIAL_VEC, RGN_FIXED_VEC,
        RGN_RESERVED, RGN_EXTERNAL, RGN_NONE
    } crs_region_t;

    // Decoder result
    typedef struct packed {
        logic [2:0] region;
        logic reserved;
        logic internal;
    } crs_decode_t;

    // Wishbone request
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [5:0] idx;
        logic [31:0] dat;
    } crs_wb_req_t;
endpackage : crs_pkg

// ---- verilog/crs_addr_decode.sv ----
`timescale 1ns/1ns
// Registered 20-bit address map decoder
module crs_addr_decode (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [19:0] addr,
    input wire logic expand_mode,
    output crs_pkg::crs_decode_t dec_ff
);
    import crs_pkg::*;

    crs_decode_t nxt_dec;

    // Region lookup, narrow regions checked before the wide ROM span
    always_comb begin
        nxt_dec = '{region: RGN_NONE, reserved: 1'b0, internal: 1'b0};
        if (addr <= ADDR_SFR_LAST) begin
            nxt_dec.region = RGN_SFR;
            nxt_dec.internal = 1'b1;
        end else if (addr >= ADDR_RAM_FIRST && addr <= ADDR_RAM_LAST) begin
            nxt_dec.region = RGN_RAM;
            nxt_dec.internal = 1'b1;
        end else if (addr >= ADDR_FIXV_FIRST) begin
            nxt_dec.region = RGN_FIXED_VEC;
            nxt_dec.internal = 1'b1;
        end else if (addr >= ADDR_SPV_FIRST && addr <= ADDR_SPV_LAST) begin
            nxt_dec.region = RGN_SPECIAL_VEC;
            nxt_dec.internal = 1'b1;
        end else if (addr >= ADDR_ROM_FIRST) begin
            nxt_dec.region = RGN_ROM;
            nxt_dec.internal = 1'b1;
        end else if (expand_mode && ((addr >= ADDR_RES0_FIRST && addr <= ADDR_RES0_LAST)
                || (addr >= ADDR_RES1_FIRST && addr <= ADDR_RES1_LAST))) begin
            nxt_dec.region = RGN_RESERVED;
            nxt_dec.reserved = 1'b1;
        end else if (expand_mode) begin
            nxt_dec.region = RGN_EXTERNAL;
        end else begin
            // Single-chip: nothing answers outside internal memory
            nxt_dec.region = RGN_NONE;
        end
    end

    // Result held in a register for a clean output
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dec_ff <= '{region: RGN_NONE, reserved: 1'b0, internal: 1'b0};
        end else begin
            dec_ff <= nxt_dec;
        end
    end
endmodule : crs_addr_decode

// ---- sim/crs_regset_sva.sv ----
// Checker for the register set bus handshake, bank output and decoder result
`timescale 1ns/1ns
module crs_regset_sva
    import crs_pkg::*;
(
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [7:2] WB_ADR_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic HW_INT_ACK,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    input wire logic WB_ERR_O,
    input wire logic [15:0] ACTIVE_SP,
    input wire logic BANK_SEL,
    input wire crs_decode_t DEC_OUT
);
    logic req;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!ARST_N);

    // A fresh request: strobe up while no answer is standing
    assign req = WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O;

    // Flag write seen on the bus; bank output lags the flag by one cycle
    property p_bank;
        logic b;
        (req && WB_WE_I && WB_ADR_I == REG_FLAGS && WB_SEL_I[0], b = WB_DAT_I[FLG_BANK_BIT])
            |-> ##2 BANK_SEL == b;
    endproperty

    a_req_answer: assert property (req |=> WB_ACK_O || WB_ERR_O)
        else $error("request got no answer");
    a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held too long");
    a_err_unmapped: assert property (req && WB_ADR_I > 6'h15 |=> WB_ERR_O && !WB_ACK_O)
        else $error("unmapped index not refused");
    a_mapped_ack: assert property (req && WB_ADR_I <= 6'h15 |=> WB_ACK_O && !WB_ERR_O)
        else $error("mapped index not acked");
    a_idle_quiet: assert property (!(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O && !WB_ERR_O)
        else $error("answer without request");
    a_data_idle: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
        else $error("read data outside ack");
    a_bank_follow: assert property (p_bank)
        else $error("bank output not following flag");
    a_dec_reserved: assert property (DEC_OUT.reserved |-> DEC_OUT.region == 3'h5)
        else $error("reserved flag with wrong region");
    a_dec_internal: assert property (DEC_OUT.internal |-> DEC_OUT.region < 3'h5)
        else $error("internal flag with wrong region");

    // Main traffic kinds
    c_write: cover property (WB_ACK_O && WB_WE_I);
    c_refuse: cover property (WB_ERR_O);
    c_bank: cover property ($rose(BANK_SEL));
    c_int_ack: cover property (HW_INT_ACK);
endmodule : crs_regset_sva

bind crs_regset crs_regset_sva u_sva (.CLK(CLK), .ARST_N(ARST_N), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_SEL_I(WB_SEL_I), .WB_ADR_I(WB_ADR_I),
    .WB_DAT_I(WB_DAT_I), .HW_INT_ACK(HW_INT_ACK), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
    .WB_ERR_O(WB_ERR_O), .ACTIVE_SP(ACTIVE_SP), .BANK_SEL(BANK_SEL), .DEC_OUT(DEC_OUT));

// ---- sim/crs_cpu_model.sv ----
// Behavioural model of the execution logic raising interrupt acknowledge
`timescale 1ns/1ns
module crs_cpu_model (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic irq_take,
    output logic int_ack
);
    // One acknowledge cycle per taken interrupt, never a held level
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            int_ack <= 1'b0;
        end else begin
            int_ack <= irq_take && !int_ack;
        end
    end
endmodule : crs_cpu_model

// ---- sim/testbench.sv ----
// Self-checking bench for the CPU register set and address decoder
`timescale 1ns/1ns
module testbench;
    import crs_pkg::*;
    logic CLK = 1'b0;
    logic ARST_N = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic irq = 1'b0;
    logic [3:0] sel = 4'h0;
    logic [5:0] adr = 6'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat, q, v;
    logic ack, err, bank, int_ack, e;
    logic [15:0] sp;
    crs_decode_t dec;
    logic [31:0] mem [0:11];
    logic [19:0] corner [0:15] = '{20'h00000, 20'h003ff, 20'h00400, 20'h017ff, 20'h01800,
        20'h03fff, 20'h04000, 20'hcffff, 20'hd0000, 20'hdffff, 20'he0000, 20'hffdff,
        20'hffe00, 20'hfffdb, 20'hfffdc, 20'hfffff};
    int failures = 0;
    int samples_checked = 0;
    integer seed = 32'h38e1;

    always #5 CLK = ~CLK;

    crs_regset u_dut (.CLK(CLK), .ARST_N(ARST_N), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_SEL_I(sel), .WB_ADR_I(adr), .WB_DAT_I(wdat), .HW_INT_ACK(int_ack),
        .WB_DAT_O(rdat), .WB_ACK_O(ack), .WB_ERR_O(err), .ACTIVE_SP(sp), .BANK_SEL(bank),
        .DEC_OUT(dec));
    crs_cpu_model u_cpu (.clk(CLK), .arst_n(ARST_N), .irq_take(irq), .int_ack(int_ack));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic results();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results

    // One classic cycle, held until the edge that sees ack or err
    task automatic bus(input logic [5:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge CLK);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        @(posedge CLK);
        while (!(ack || err) && n < 50) begin
            n++;
            @(posedge CLK);
        end
        if (n == 50) failures++;
        q = rdat;
        e = err;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : bus

    // PC and vector base are 20 bits, the rest 16
    function automatic logic [31:0] wmask(input int i);
        return (i == 7 || i == 8) ? 32'h000fffff : 32'h0000ffff;
    endfunction : wmask

    // Region, reserved, internal expected for an address in a mode
    function automatic crs_decode_t exp_dec(input logic [19:0] a, input logic m);
        if (a <= 20'h003ff) return {3'h0, 2'b01};
        if (a >= 20'h00400 && a <= 20'h017ff) return {3'h1, 2'b01};
        if (a >= 20'hfffdc) return {3'h4, 2'b01};
        if (a >= 20'hffe00) return {3'h3, 2'b01};
        if (a >= 20'he0000) return {3'h2, 2'b01};
        if (!m) return {3'h7, 2'b00};
        if ((a >= 20'h01800 && a <= 20'h03fff) || a[19:16] == 4'hd) return {3'h5, 2'b10};
        return {3'h6, 2'b00};
    endfunction : exp_dec

    // Hang guard, far beyond the expected run length
    initial begin
        #200000;
        failures++;
        results();
    end

    initial begin
        repeat (5) @(posedge CLK);
        ARST_N <= 1'b1;
        for (int i = 0; i < 14; i++) begin
            bus(i[5:0], 1'b0, 32'h0);
            check(q, 32'h0);
        end
        // Random fill of bank zero and the unbanked registers up to static base, then read-back
        for (int i = 0; i < 12; i++) begin
            v = $random(seed);
            bus(i[5:0], 1'b1, v);
            mem[i] = v & wmask(i);
        end
        for (int i = 0; i < 12; i++) begin
            bus(i[5:0], 1'b0, 32'h0);
            check(q, mem[i]);
        end
        bus(REG_WIDE_DATA_LO, 1'b0, 32'h0);
        check(q, {mem[2][15:0], mem[0][15:0]});
        bus(REG_WIDE_DATA_HI, 1'b0, 32'h0);
        check(q, {mem[3][15:0], mem[1][15:0]});
        bus(REG_WIDE_ADDR, 1'b0, 32'h0);
        check(q, {mem[5][15:0], mem[4][15:0]});
        bus(REG_BYTE_LO, 1'b0, 32'h0);
        check(q, {16'h0, mem[1][7:0], mem[0][7:0]});
        bus(REG_BYTE_HI, 1'b0, 32'h0);
        check(q, {16'h0, mem[1][15:8], mem[0][15:8]});
        // Only implemented flag bits stick; bank one and user stack come up
        bus(REG_FLAGS, 1'b1, 32'hffffffff);
        bus(REG_FLAGS, 1'b0, 32'h0);
        check(q, 32'h000070ff);
        check({31'h0, bank}, 32'h1);
        check({16'h0, sp}, mem[9]);
        for (int i = 0; i < 7; i++) begin
            bus(i[5:0], 1'b0, 32'h0);
            check(q, 32'h0);
            bus(i[5:0], 1'b1, ~mem[i]);
        end
        bus(REG_FLAGS, 1'b1, 32'h00000080);
        for (int i = 0; i < 7; i++) begin
            bus(i[5:0], 1'b0, 32'h0);
            check(q, mem[i]);
        end
        // Interrupt acknowledge drops back to the interrupt stack
        @(posedge CLK);
        irq <= 1'b1;
        @(posedge CLK);
        irq <= 1'b0;
        repeat (3) @(posedge CLK);
        check({16'h0, sp}, mem[10]);
        bus(REG_FLAGS, 1'b0, 32'h0);
        check(q, 32'h0);
        bus(6'h16, 1'b0, 32'h0);
        check({31'h0, e}, 32'h1);
        // Corner and random probe addresses in both processor modes
        for (int m = 0; m < 2; m++) begin
            bus(REG_MODE, 1'b1, 32'(m));
            for (int k = 0; k < 24; k++) begin
                v = (k < 16) ? {12'h0, corner[k]} : {12'h0, 20'($random(seed))};
                bus(REG_DEC_ADDR, 1'b1, v);
                repeat (3) @(posedge CLK);
                check({27'h0, dec}, {27'h0, exp_dec(v[19:0], m[0])});
            end
        end
        results();
    end
endmodule : testbench
